// ### dsc_deep_sleep_controller.sv
`default_nettype none

// Function
// [RL1] Sleep with the arm bit set enters deep sleep, else ordinary sleep.
// [RL2] Firmware issues the sleep instruction right after setting the arm bit.
// [RL3] Arm bit clears itself two instruction cycles after being set.
// [RL4] Firmware sets regulator sleep select and clears idle-on-sleep before arming.
// [RL5] Firmware waits for calendar sync clear before calendar-alarm sleep.
// [RL6] Any wake event in deep sleep runs a full power-on reset of the core.
// [RL7] Exit flag is set after leaving deep sleep and stays until firmware clears it.
// [RL8] Firmware reads causes, flag and scratch before clearing release.
// [RL9] A fault during deep sleep sets the fault cause bit and wakes the device.
// [RL10] Fault monitoring is always on in deep sleep and needs no setup.
// [RL11] Calendar keeps running through deep sleep and its alarm can wake.
// [RL12] Calendar clock source is chosen by the configuration clock select bit.
// [RL13] Calendar wake disable bit blocks calendar alarm wakes when set.
// [RL14] ULP module enable keeps the ULP wake module running in deep sleep.
// [RL15] ULP wake disable blocks ULP wakes; else they need the module enable.
// [RL16] Firmware writes zero to reserved bit 2; bits 6 to 3 read zero.
// [RL17] Brown-out flag sets when enabled supply sags below arming, not trip.
// [RL18] Pins hold their deep sleep states until firmware clears the release bit; the code also releases them on an MCLR or trip wake.
// [RL19] Brown-out flag and release bit reset only at first power-up; the code also clears the release bit on an MCLR or trip wake.
// [RL20] The 8-bit scratch register is read/write and survives deep sleep and wake.
// [RL21] Scratch lost on core brown-out, deep sleep trip or power cycle.
// [RL22] Entering deep sleep clears both wake cause registers.
// [RL23] Only the first wake source to assert is recorded in the wake causes.
// [RL24] Deep sleep powers the core down while the always-on logic keeps running.
module dsc_deep_sleep_controller (
    // APB slave.
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire dsc_pkg::dsc_apb_req_t   apb_req,
    output var  dsc_pkg::dsc_apb_rsp_t   apb_rsp,
    // CPU core.
    input  wire logic                    instr_tick,
    input  wire logic                    sleep_instr,
    input  wire logic                    core_brownout,
    output logic                         core_power_on,
    output logic                         core_reset_n,
    output logic                         light_sleep,
    // Wake sources and supply monitor.
    input  wire dsc_pkg::dsc_wake_t      wake_in,
    input  wire logic                    supply_below_arm,
    input  wire logic                    supply_below_trip,
    output logic                         calendar_run,
    output logic                         calendar_clock_select,
    output logic                         ulp_module_run,
    output logic                         fault_monitor_on,
    // Pins.
    input  wire logic [dsc_pkg::PIN_W-1:0] pin_direction,
    input  wire logic [dsc_pkg::PIN_W-1:0] pin_latch,
    output logic      [dsc_pkg::PIN_W-1:0] pin_direction_out,
    output logic      [dsc_pkg::PIN_W-1:0] pin_latch_out
);
    import dsc_pkg::*;

    dsc_state_reg_t st_reg;
    dsc_state_reg_t st_next;

    logic       setup;
    logic       wr_en;
    logic       hit;
    logic [7:0] rd_byte;
    logic [7:0] wd;
    logic       wake_cal;
    logic       wake_ulp;
    logic       wake_any;
    logic       bor_trip;
    logic       clear_exit;

    // ----------------
    // Bus decode and read mux.
    // ----------------
    always_comb begin
        setup   = apb_req.psel && !apb_req.penable;
        wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite;
        wd      = apb_req.pwdata[7:0];
        hit     = 1'b1;
        rd_byte = 8'h00;
        if (apb_req.paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end else if (apb_req.paddr[31:2] == IDX_WAKE_CAUSE_LOW) begin
            rd_byte = st_reg.wake_low;
        end else if (apb_req.paddr[31:2] == IDX_WAKE_CAUSE_HIGH) begin
            rd_byte = {7'h00, st_reg.wake_high};
        end else if (apb_req.paddr[31:2] == IDX_SLEEP_CONTROL_LOW) begin
            rd_byte = {5'h00, st_reg.ulp_wdis, st_reg.bor_flag, st_reg.release_hold};
        end else if (apb_req.paddr[31:2] == IDX_SLEEP_CONTROL_HI) begin
            rd_byte = {st_reg.arm, 4'h0, st_reg.reserved_hi,                 // [RL16]
                       st_reg.ulp_on, st_reg.cal_wdis};
        end else if (apb_req.paddr[31:2] == IDX_SCRATCH_0) begin
            rd_byte = st_reg.scratch;                                        // [RL20]
        end else if (apb_req.paddr[31:2] == IDX_WATCHDOG_CONTROL) begin
            rd_byte = {st_reg.reg_sleep, 3'h0, st_reg.exit_flag, 3'h0};
        end else if (apb_req.paddr[31:2] == IDX_OSC_CONTROL) begin
            rd_byte = {st_reg.idle_on, 7'h00};
        end else if (apb_req.paddr[31:2] == IDX_CONFIG_THREE_LOW) begin
            rd_byte = {6'h00, st_reg.cal_clk_sel, st_reg.bor_en};
        end else begin
            hit = 1'b0;
        end
    end

    // ----------------
    // Wake qualification.
    // ----------------
    always_comb begin
        wake_cal = wake_in.calendar_alarm && !st_reg.cal_wdis;                 // [RL13] [RL11]
        wake_ulp = wake_in.ulp_wake_unit && st_reg.ulp_on && !st_reg.ulp_wdis; // [RL15]
        bor_trip = st_reg.bor_en && supply_below_trip;
        wake_any = wake_cal || wake_ulp || wake_in.fault || wake_in.mclr      // [RL10]
                   || wake_in.sleep_watchdog || wake_in.ext_interrupt_zero || bor_trip;
        clear_exit = wr_en && (apb_req.paddr[31:2] == IDX_WATCHDOG_CONTROL)
                     && (apb_req.paddr[1:0] == 2'h0) && !wd[WD_EXIT_FLAG];
    end

    // ----------------
    // Next state.
    // ----------------
    always_comb begin
        st_next             = st_reg;
        st_next.light_sleep = 1'b0;

        // Register writes take effect in the access phase.
        if (wr_en && hit) begin
            if (apb_req.paddr[31:2] == IDX_WAKE_CAUSE_LOW) begin
                st_next.wake_low = wd & 8'hBD;
            end else if (apb_req.paddr[31:2] == IDX_WAKE_CAUSE_HIGH) begin
                st_next.wake_high = wd[WH_EXT_INTERRUPT_ZERO];
            end else if (apb_req.paddr[31:2] == IDX_SLEEP_CONTROL_LOW) begin
                st_next.ulp_wdis     = wd[LO_ULP_WDIS];
                st_next.bor_flag     = wd[LO_BOR_FLAG];
                st_next.release_hold = wd[LO_RELEASE];                      // [RL18]
            end else if (apb_req.paddr[31:2] == IDX_SLEEP_CONTROL_HI) begin
                st_next.arm         = wd[HI_ARM];
                st_next.arm_age     = 2'h0;
                st_next.reserved_hi = wd[HI_RESERVED];
                st_next.ulp_on      = wd[HI_ULP_ON];                        // [RL14]
                st_next.cal_wdis    = wd[HI_CAL_WDIS];
            end else if (apb_req.paddr[31:2] == IDX_SCRATCH_0) begin
                st_next.scratch = wd;                                       // [RL20]
            end else if (apb_req.paddr[31:2] == IDX_WATCHDOG_CONTROL) begin
                st_next.reg_sleep = wd[WD_REG_SLEEP];
            end else if (apb_req.paddr[31:2] == IDX_OSC_CONTROL) begin
                st_next.idle_on = wd[OSC_IDLE];
            end else if (apb_req.paddr[31:2] == IDX_CONFIG_THREE_LOW) begin
                st_next.cal_clk_sel = wd[CFG_CAL_CLK];                      // [RL12]
                st_next.bor_en      = wd[CFG_BOR_EN];
            end
        end
        if (clear_exit) begin
            st_next.exit_flag = 1'b0;
        end

        // Arm bit ages on instruction cycles and drops after the second.
        if (st_reg.arm && !(wr_en && apb_req.paddr[31:2] == IDX_SLEEP_CONTROL_HI)
            && instr_tick) begin
            if (st_reg.arm_age == ARM_LIFE_CYCLES - 2'h1) begin
                st_next.arm     = 1'b0;                                     // [RL3]
                st_next.arm_age = 2'h0;
            end else begin
                st_next.arm_age = st_reg.arm_age + 2'h1;
            end
        end

        // Core brown-out while running loses the scratch contents.
        if (st_reg.state == DSC_RUN && core_brownout) begin
            st_next.scratch = 8'h00;                                        // [RL21]
        end

        // Bus response is registered in the setup phase.
        if (setup) begin
            st_next.prdata  = {24'h00_0000, rd_byte};
            st_next.pslverr = !hit;
        end

        case (st_reg.state)
            DSC_RUN: begin
                if (sleep_instr && st_reg.arm) begin                        // [RL1] [RL2] [RL4]
                    st_next.state        = DSC_DEEP;                        // [RL24]
                    st_next.arm          = 1'b0;
                    st_next.arm_age      = 2'h0;
                    st_next.wake_low     = 8'h00;                           // [RL22]
                    st_next.wake_high    = 1'b0;
                    st_next.release_hold = 1'b1;                            // [RL18]
                    st_next.hold_dir     = pin_direction;
                    st_next.hold_lat     = pin_latch;
                end else if (sleep_instr) begin
                    st_next.light_sleep = 1'b1;                             // [RL1]
                end
            end
            DSC_DEEP: begin
                if (st_reg.bor_en && supply_below_arm && !supply_below_trip) begin
                    st_next.bor_flag = 1'b1;                                // [RL17]
                end
                if (wake_any) begin
                    // One source is logged; simultaneous ones resolve by fixed order.
                    if (wake_in.fault) begin
                        st_next.wake_low[WL_FAULT] = 1'b1;                  // [RL9] [RL23]
                    end else if (bor_trip) begin
                        st_next.wake_low[WL_POR] = 1'b1;
                        st_next.scratch          = 8'h00;                   // [RL21]
                        st_next.release_hold     = 1'b0;
                    end else if (wake_in.mclr) begin
                        st_next.wake_low[WL_MCLR] = 1'b1;                   // [RL23]
                        st_next.release_hold      = 1'b0;
                    end else if (wake_cal) begin
                        st_next.wake_low[WL_CALENDAR] = 1'b1;
                    end else if (wake_in.sleep_watchdog) begin
                        st_next.wake_low[WL_WATCHDOG] = 1'b1;
                    end else if (wake_ulp) begin
                        st_next.wake_low[WL_ULP] = 1'b1;
                    end else begin
                        st_next.wake_high = 1'b1;
                    end
                    st_next.state   = DSC_WAKE_POR;                         // [RL6]
                    st_next.por_cnt = WAKE_POR_CYCLES;
                end
            end
            DSC_WAKE_POR: begin
                // The core reset wipes the core-domain control bits.
                st_next.arm       = 1'b0;
                st_next.arm_age   = 2'h0;
                st_next.reg_sleep = 1'b0;
                st_next.idle_on   = 1'b0;
                if (st_reg.por_cnt == 8'h01) begin
                    st_next.state     = DSC_RUN;                            // [RL6]
                    st_next.exit_flag = 1'b1;                               // [RL7]
                    st_next.por_cnt   = 8'h00;
                end else begin
                    st_next.por_cnt = st_reg.por_cnt - 8'h01;
                end
            end
            default: begin
                st_next.state = DSC_RUN;
            end
        endcase
    end

    // ----------------
    // State register; cleared only at first power-up.
    // ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg          <= '0;                                          // [RL19]
            st_reg.state    <= DSC_RUN;
            st_reg.wake_low <= WAKE_LOW_POR_VALUE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------
    // Outputs.
    // ----------------
    always_comb begin
        apb_rsp.pready        = 1'b1;
        apb_rsp.pslverr       = st_reg.pslverr && apb_req.psel && apb_req.penable;
        apb_rsp.prdata        = st_reg.prdata;
        core_power_on         = (st_reg.state == DSC_RUN);                  // [RL24]
        core_reset_n          = (st_reg.state == DSC_RUN);                  // [RL6]
        light_sleep           = st_reg.light_sleep;
        calendar_run          = 1'b1;                                       // [RL11]
        calendar_clock_select = st_reg.cal_clk_sel;                         // [RL12]
        ulp_module_run        = st_reg.ulp_on || (st_reg.state == DSC_RUN); // [RL14]
        fault_monitor_on      = (st_reg.state == DSC_DEEP);                 // [RL10]
        pin_direction_out     = st_reg.release_hold ? st_reg.hold_dir : pin_direction; // [RL18]
        pin_latch_out         = st_reg.release_hold ? st_reg.hold_lat : pin_latch;
    end

endmodule

`default_nettype wire

// ### dsc_pkg.sv
`default_nettype none

package dsc_pkg;

    // ----------------
    // Register indices; the byte address is four times the index.
    // ----------------
    localparam logic [29:0] IDX_WAKE_CAUSE_LOW    = 30'h0000_0F4A;
    localparam logic [29:0] IDX_WAKE_CAUSE_HIGH   = 30'h0000_0F4B;
    localparam logic [29:0] IDX_SLEEP_CONTROL_LOW = 30'h0000_0F4C;
    localparam logic [29:0] IDX_SLEEP_CONTROL_HI  = 30'h0000_0F4D;
    localparam logic [29:0] IDX_SCRATCH_0         = 30'h0000_0F4E;
    localparam logic [29:0] IDX_WATCHDOG_CONTROL  = 30'h0000_0F50;
    localparam logic [29:0] IDX_OSC_CONTROL       = 30'h0000_0F51;
    localparam logic [29:0] IDX_CONFIG_THREE_LOW  = 30'h0000_0F52;

    // ----------------
    // Field positions.
    // ----------------
    localparam int HI_ARM        = 7;
    localparam int HI_RESERVED   = 2;
    localparam int HI_ULP_ON     = 1;
    localparam int HI_CAL_WDIS   = 0;
    localparam int LO_ULP_WDIS   = 2;
    localparam int LO_BOR_FLAG   = 1;
    localparam int LO_RELEASE    = 0;
    localparam int WL_FAULT      = 7;
    localparam int WL_ULP        = 5;
    localparam int WL_WATCHDOG   = 4;
    localparam int WL_CALENDAR   = 3;
    localparam int WL_MCLR       = 2;
    localparam int WL_POR        = 0;
    localparam int WH_EXT_INTERRUPT_ZERO       = 0;
    localparam int WD_REG_SLEEP  = 7;
    localparam int WD_EXIT_FLAG  = 3;
    localparam int OSC_IDLE      = 7;
    localparam int CFG_CAL_CLK   = 1;
    localparam int CFG_BOR_EN    = 0;

    // ----------------
    // Reset values and timing.
    // ----------------
    localparam logic [7:0] WAKE_LOW_POR_VALUE = 8'h01;
    localparam logic [1:0] ARM_LIFE_CYCLES    = 2'h2;
    localparam int         CLK_PERIOD_PS      = 5000;
    localparam int         WAKE_POR_NS        = 100;
    localparam int         WAKE_POR_RAW       = (WAKE_POR_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [7:0] WAKE_POR_CYCLES    = 8'(WAKE_POR_RAW < 1 ? 1 : WAKE_POR_RAW);
    localparam int         PIN_W              = 8;

    typedef enum logic [1:0] {
        DSC_RUN,
        DSC_DEEP,
        DSC_WAKE_POR
    } dsc_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } dsc_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } dsc_apb_rsp_t;

    typedef struct packed {
        logic calendar_alarm;
        logic ext_interrupt_zero;
        logic ulp_wake_unit;
        logic sleep_watchdog;
        logic mclr;
        logic fault;
    } dsc_wake_t;

    typedef struct packed {
        dsc_state_t       state;
        logic             arm;
        logic [1:0]       arm_age;
        logic             reserved_hi;
        logic             ulp_on;
        logic             cal_wdis;
        logic             ulp_wdis;
        logic             bor_flag;
        logic             release_hold;
        logic [7:0]       scratch;
        logic [7:0]       wake_low;
        logic             wake_high;
        logic             exit_flag;
        logic             reg_sleep;
        logic             idle_on;
        logic             cal_clk_sel;
        logic             bor_en;
        logic [7:0]       por_cnt;
        logic             light_sleep;
        logic [PIN_W-1:0] hold_dir;
        logic [PIN_W-1:0] hold_lat;
        logic [31:0]      prdata;
        logic             pslverr;
    } dsc_state_reg_t;

endpackage

`default_nettype wire

// ### dsc_assertions.sv
`default_nettype none

module dsc_assertions (
    // Clock and reset.
    input wire logic                  pclk,
    input wire logic                  presetn,
    // Observed ports.
    input wire dsc_pkg::dsc_apb_req_t apb_req,
    input wire dsc_pkg::dsc_apb_rsp_t apb_rsp,
    input wire logic                  sleep_instr,
    input wire logic                  core_power_on,
    input wire logic                  core_reset_n,
    input wire logic                  light_sleep,
    input wire logic                  calendar_run,
    input wire logic                  fault_monitor_on,
    input wire logic [7:0]            pin_direction_out,
    input wire logic [7:0]            pin_latch_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import dsc_pkg::*;

    // ----------------
    // Sleep entry, wake reset and register checks.
    // ----------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    deep_entry_a: assert property ($rose(fault_monitor_on) |-> $past(sleep_instr))
        else $error("deep sleep entered without a sleep instruction");
    sleep_outcome_a: assert property (sleep_instr && core_power_on |=>
        light_sleep || fault_monitor_on)
        else $error("sleep instruction gave neither sleep kind");
    light_sleep_a: assert property (light_sleep |-> $past(sleep_instr) && core_power_on)
        else $error("light sleep pulse without cause");
    core_off_a: assert property (fault_monitor_on |-> !core_power_on && !core_reset_n)
        else $error("core powered while in deep sleep");
    wake_por_a: assert property ($fell(fault_monitor_on) |-> (!core_power_on [*8] ##1
        !core_power_on [*8] ##1 !core_power_on [*4]) ##1 core_power_on && core_reset_n)
        else $error("wake reset length wrong");
    pin_hold_a: assert property (fault_monitor_on && $past(fault_monitor_on) |->
        $stable(pin_direction_out) && $stable(pin_latch_out))
        else $error("pins moved during deep sleep");
    calendar_on_a: assert property (calendar_run)
        else $error("calendar stopped");
    reserved_zero_a: assert property (apb_req.psel && apb_req.penable && !apb_req.pwrite &&
        apb_req.paddr == {IDX_SLEEP_CONTROL_HI, 2'b00} |-> apb_rsp.prdata[6:3] == 4'h0)
        else $error("unimplemented control bits read nonzero");

    cover property ($rose(fault_monitor_on));
    cover property (light_sleep);
    cover property ($rose(core_reset_n));
endmodule

bind dsc_deep_sleep_controller dsc_assertions i_dsc_assertions (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .sleep_instr(sleep_instr), .core_power_on(core_power_on), .core_reset_n(core_reset_n),
    .light_sleep(light_sleep), .calendar_run(calendar_run),
    .fault_monitor_on(fault_monitor_on), .pin_direction_out(pin_direction_out),
    .pin_latch_out(pin_latch_out));

`default_nettype wire

// ### dsc_core_model.sv
`default_nettype none

module dsc_core_model (
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Firmware command.
    input  wire logic       go,
    input  wire logic [1:0] late,
    // Instruction stream.
    output logic            instr_tick,
    output logic            sleep_instr
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------
    // One instruction every four clocks; sleep follows a command.
    // ----------------
    logic [1:0] phase_reg;
    logic       pend_reg;
    logic [1:0] left_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg   <= 2'h0;
            pend_reg    <= 1'b0;
            left_reg    <= 2'h0;
            instr_tick  <= 1'b0;
            sleep_instr <= 1'b0;
        end else begin
            phase_reg   <= phase_reg + 2'h1;
            instr_tick  <= (phase_reg == 2'h3);
            sleep_instr <= 1'b0;
            if (go) begin
                pend_reg <= 1'b1;
                left_reg <= late;
            end else if (pend_reg && left_reg == 2'h0) begin
                sleep_instr <= 1'b1;
                pend_reg    <= 1'b0;
            end else if (pend_reg && instr_tick) begin
                left_reg <= left_reg - 2'h1;
            end
        end
    end
endmodule

`default_nettype wire

// ### dsc_deep_sleep_controller_test.sv
`default_nettype none

module dsc_deep_sleep_controller_test;
    timeunit 1ns;
    timeprecision 100ps;
    import dsc_pkg::*;

    logic         pclk, presetn, go, instr_tick, sleep_instr, core_brownout, err;
    logic         supply_below_arm, supply_below_trip, core_power_on, core_reset_n;
    logic         light_sleep, calendar_run, calendar_clock_select, ulp_module_run;
    logic         fault_monitor_on;
    logic [1:0]   late;
    logic [7:0]   pdir, plat, pdir_o, plat_o, rd, scr;
    logic [31:0]  seed;
    dsc_apb_req_t req;
    dsc_apb_rsp_t rsp;
    dsc_wake_t    wake;
    int           bad_count, samples_checked;
    // Wake bits 6..0: trip, calendar, ext_interrupt_zero, ulp, watchdog, mclr, fault.
    logic [7:0]   t_hi[7]  = '{8'h80, 8'h81, 8'h80, 8'h82, 8'h82, 8'h80, 8'h80};
    logic [7:0]   t_lo[7]  = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
    logic [5:0]   t_blk[7] = '{6'h00, 6'h20, 6'h08, 6'h08, 6'h00, 6'h00, 6'h00};
    logic [6:0]   t_wk[7]  = '{7'h30, 7'h01, 7'h04, 7'h10, 7'h08, 7'h02, 7'h40};

    dsc_deep_sleep_controller i_dsc_deep_sleep_controller (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .instr_tick(instr_tick), .sleep_instr(sleep_instr), .core_brownout(core_brownout),
        .core_power_on(core_power_on), .core_reset_n(core_reset_n), .light_sleep(light_sleep),
        .wake_in(wake), .supply_below_arm(supply_below_arm),
        .supply_below_trip(supply_below_trip), .calendar_run(calendar_run),
        .calendar_clock_select(calendar_clock_select), .ulp_module_run(ulp_module_run),
        .fault_monitor_on(fault_monitor_on), .pin_direction(pdir), .pin_latch(plat),
        .pin_direction_out(pdir_o), .pin_latch_out(plat_o));

    dsc_core_model i_dsc_core_model (
        .pclk(pclk), .presetn(presetn), .go(go), .late(late),
        .instr_tick(instr_tick), .sleep_instr(sleep_instr));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ----------------
    // Bench tasks and the reference model.
    // ----------------
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    // Highest-priority qualified source gives {high cause, low cause}.
    function automatic logic [8:0] exp_cause(input logic [6:0] w, input logic [7:0] hi, lo);
        if (w[6]) return 9'h001;
        if (w[0]) return 9'h080;
        if (w[1]) return 9'h004;
        if (w[5] && !hi[0]) return 9'h008;
        if (w[2]) return 9'h010;
        if (w[3] && hi[1] && !lo[2]) return 9'h020;
        return w[4] ? 9'h100 : 9'h000;
    endfunction

    task automatic results();
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [29:0] idx, input logic [7:0] wd);
        int n;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: {24'h0, wd}};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            bad_count++;
            results();
        end
        rd = rsp.prdata[7:0];
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdc(input logic [29:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check8(rd, exp);
    endtask

    task automatic wait_hi(input int sel, input int lim);
        int n;
        n = 0;
        while ((sel == 0 ? fault_monitor_on : sel == 1 ? core_power_on : light_sleep) !== 1'b1)
        begin
            @(posedge pclk);
            n++;
            if (n > lim) begin
                bad_count++;
                results();
            end
        end
    endtask

    task automatic deep_cycle(input int i);
        logic [8:0] ec;
        logic [7:0] hd, hl;
        logic       rel;
        ec = exp_cause(t_wk[i] | {1'b0, t_blk[i]}, t_hi[i], t_lo[i]);
        rel = !(t_wk[i][6] || t_wk[i][1]);
        hd = xs();
        hl = xs();
        apb(1'b1, IDX_SLEEP_CONTROL_LOW, t_lo[i]);
        apb(1'b1, IDX_WATCHDOG_CONTROL, 8'h80);
        apb(1'b1, IDX_OSC_CONTROL, 8'h00);
        scr = xs();
        apb(1'b1, IDX_SCRATCH_0, scr);
        pdir <= hd;
        plat <= hl;
        apb(1'b1, IDX_SLEEP_CONTROL_HI, t_hi[i]);
        go <= 1'b1;
        late <= 2'h0;
        @(posedge pclk);
        go <= 1'b0;
        wait_hi(0, 40);
        check8({7'h0, core_power_on}, 8'h00);
        check8({7'h0, ulp_module_run}, {7'h0, t_hi[i][1]});
        wake <= dsc_wake_t'(t_blk[i]);
        supply_below_arm <= !t_wk[i][6];
        pdir <= xs();
        plat <= xs();
        repeat (12) @(posedge pclk);
        check8({7'h0, core_power_on}, 8'h00);
        wake <= dsc_wake_t'(t_blk[i] | t_wk[i][5:0]);
        supply_below_trip <= t_wk[i][6];
        wait_hi(1, 60);
        wake <= '0;
        supply_below_arm <= 1'b0;
        supply_below_trip <= 1'b0;
        @(negedge pclk);
        check8(pdir_o, rel ? hd : pdir);
        check8(plat_o, rel ? hl : plat);
        @(posedge pclk);
        rdc(IDX_WATCHDOG_CONTROL, 8'h08);
        rdc(IDX_WAKE_CAUSE_LOW, ec[7:0]);
        rdc(IDX_WAKE_CAUSE_HIGH, {7'h0, ec[8]});
        apb(1'b0, IDX_SLEEP_CONTROL_LOW, 8'h00);
        check8(rd & 8'h03, {6'h0, !t_wk[i][6], rel});
        rdc(IDX_SCRATCH_0, t_wk[i][6] ? 8'h00 : scr);
        apb(1'b1, IDX_SLEEP_CONTROL_LOW, 8'h00);
        apb(1'b1, IDX_WATCHDOG_CONTROL, 8'h00);
        rdc(IDX_WATCHDOG_CONTROL, 8'h00);
        @(negedge pclk);
        check8(pdir_o, pdir);
        @(posedge pclk);
    endtask

    // ----------------
    // Main sequence.
    // ----------------
    initial begin
        presetn = 1'b0;
        req = '0;
        wake = '0;
        go = 1'b0;
        late = 2'h0;
        core_brownout = 1'b0;
        supply_below_arm = 1'b0;
        supply_below_trip = 1'b0;
        pdir = 8'h00;
        plat = 8'h00;
        seed = 32'h6922;
        bad_count = 0;
        samples_checked = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(IDX_SLEEP_CONTROL_LOW, 8'h00);
        rdc(IDX_SLEEP_CONTROL_HI, 8'h00);
        rdc(IDX_WAKE_CAUSE_LOW, WAKE_LOW_POR_VALUE);
        apb(1'b0, 30'h0000_0F4F, 8'h00);
        check8({7'h0, err}, 8'h01);
        apb(1'b1, IDX_CONFIG_THREE_LOW, 8'h03);
        check8({7'h0, calendar_clock_select}, 8'h01);
        apb(1'b1, IDX_SCRATCH_0, xs());
        core_brownout <= 1'b1;
        @(posedge pclk);
        core_brownout <= 1'b0;
        @(posedge pclk);
        rdc(IDX_SCRATCH_0, 8'h00);
        apb(1'b1, IDX_SLEEP_CONTROL_HI, 8'hFB);
        go <= 1'b1;
        late <= 2'h3;
        @(posedge pclk);
        go <= 1'b0;
        wait_hi(2, 60);
        check8({7'h0, core_power_on}, 8'h01);
        rdc(IDX_SLEEP_CONTROL_HI, 8'h03);
        for (int i = 0; i < 7; i++) begin
            deep_cycle(i);
        end
        results();
    end
endmodule

`default_nettype wire
